/* core/fpc_pkg.sv */
/*
 * fpc_pkg: constants and carrier types for the front panel controller.
 * assumes a 125 MHz system clock; all times are converted to cycles here.
 */
package fpc_pkg;

    // ************************************************************
    // timing
    // ************************************************************
    localparam int unsigned CLK_MHZ          = 125;
    localparam int unsigned TOGGLE_HOLD_MS   = 3000;
    localparam int unsigned ACTION_HOLD_MS   = 5000;
    localparam int unsigned BLINK_HALF_MS    = 250;
    localparam int unsigned IP_SHOW_MS       = 1000;
    localparam longint unsigned TOGGLE_HOLD_CYC = longint'(TOGGLE_HOLD_MS) * 1000 * CLK_MHZ;
    localparam longint unsigned ACTION_HOLD_CYC = longint'(ACTION_HOLD_MS) * 1000 * CLK_MHZ;
    localparam longint unsigned BLINK_HALF_CYC  = longint'(BLINK_HALF_MS) * 1000 * CLK_MHZ;
    localparam longint unsigned IP_SHOW_CYC     = longint'(IP_SHOW_MS) * 1000 * CLK_MHZ;

    // ************************************************************
    // selector settings and values
    // ************************************************************
    localparam logic [3:0] SEL_TOGGLE_TENS  = 4'h8;
    localparam logic [3:0] SEL_TOGGLE_UNITS = 4'h9;
    localparam logic [3:0] SEL_SD_TENS      = 4'h1;
    localparam logic [3:0] SEL_LOAD_UNITS   = 4'h0;
    localparam logic [3:0] SEL_SAVE_UNITS   = 4'h1;
    localparam logic [3:0] SEL_STOP_UNITS   = 4'h2;
    localparam logic [3:0] SEL_RESTART_UNITS = 4'h3;
    localparam logic [3:0] SEL_SINGLE_SW    = 4'h1;
    localparam logic [3:0] SEL_SINGLE_MIN   = 4'h2;
    localparam logic [3:0] SEL_SINGLE_MAX   = 4'h9;
    localparam logic [7:0] SINGLE_OCTET_BASE = 8'h64;
    localparam logic [1:0] ACTIVE_DYN_BRAKE = 2'h3;

    // ************************************************************
    // display character codes
    // ************************************************************
    localparam logic [7:0] CH_LOADING = 8'h2D;
    localparam logic [7:0] CH_OPER    = 8'h6F;
    localparam logic [7:0] CH_FAULT   = 8'h46;
    localparam logic [7:0] CH_WARN    = 8'h6E;
    localparam logic [7:0] CH_IP_I    = 8'h49;
    localparam logic [7:0] CH_IP_P    = 8'h50;
    localparam logic [7:0] CH_DNLD    = 8'h64;
    localparam logic [7:0] CH_DIGIT0  = 8'h30;
    localparam logic [7:0] CH_BLANK   = 8'h20;

    typedef enum logic [1:0] {
        ADDR_DHCP,
        ADDR_STATIC_SEL,
        ADDR_STATIC_CFG
    } fpc_addr_mode_t;

    typedef struct packed {
        fpc_addr_mode_t mode;
        logic [7:0]     last_octet;
        logic           valid;
    } fpc_addr_t;

    typedef struct packed {
        logic [7:0] left;
        logic [7:0] right;
        logic       dp;
    } fpc_disp_t;

    typedef struct packed {
        logic fieldbus_toggle;
        logic sd_load;
        logic sd_save;
        logic prog_stop;
        logic prog_restart;
    } fpc_req_t;

endpackage

/* core/fpc_front_panel.sv */
/*
 * fpc_front_panel: front panel logic of a servo drive. Decodes rotary
 * selectors at power-up, times the front push button and raises action
 * requests, and chooses the two character display codes.
 * assumes selectors and button are asynchronous pins; drive status inputs
 * come from logic on clk. rst_n is the logic-supply power-on reset.
 */
// Overview of operation
// R1: both selectors zero at power-up: DHCP
// R2: otherwise static address, octet 01..99 only
// R3: 8/9, enabled power, disabled, 3 s: toggle fieldbus
// R4: 1/0 with io option, 5 s: SD load
// R5: 1/1 with io option, 5 s: SD save
// R6: 1/2 programmable variant, 5 s: stop program
// R7: 1/3 programmable variant, 5 s: restart program
// R8: single selector 0 at power-up: DHCP
// R9: single selector 1: software-configured static address
// R10: single selector 2..9: octet 100 plus value
// R11: short press shows network address
// R12: display o mode, F fault, n warning, IP, d
// R13: point steady when enabled, flashing in state 3
// R14: loading indication until logic image is ready
// R15: SD requests only when stopped and disabled
// R16: hold timer counts while held, fires once
// R17: short release is short press; undefined settings idle
`timescale 1ns/1ps
module fpc_front_panel #(
    parameter longint unsigned TOGGLE_CYC = fpc_pkg::TOGGLE_HOLD_CYC,
    parameter longint unsigned ACTION_CYC = fpc_pkg::ACTION_HOLD_CYC,
    parameter longint unsigned BLINK_CYC  = fpc_pkg::BLINK_HALF_CYC,
    parameter longint unsigned IPSHOW_CYC = fpc_pkg::IP_SHOW_CYC,
    parameter int unsigned     CNT_W      = 30
) (
    // clock and reset
    input  wire logic              clk,
    input  wire logic              rst_n,
    // variant straps
    input  wire logic              single_selector_variant,
    input  wire logic              fieldbus_variant,
    input  wire logic              io_expansion_option,
    input  wire logic              programmable_variant,
    // operator pins
    input  wire logic [3:0]        tens_rotary_selector,
    input  wire logic [3:0]        units_rotary_selector,
    input  wire logic [3:0]        single_rotary_selector,
    input  wire logic              front_push_button,
    // drive state
    input  wire logic              logic_image_ready,
    input  wire logic              power_present,
    input  wire logic              drive_enabled,
    input  wire logic              program_running,
    input  wire logic [1:0]        drive_activity_state,
    input  wire logic [1:0]        operating_mode,
    input  wire logic              fault_active,
    input  wire logic [3:0]        fault_code,
    input  wire logic              warning_active,
    input  wire logic [3:0]        warning_code,
    input  wire logic              download_active,
    input  wire logic [3:0]        download_step,
    input  wire logic [7:0]        current_octet,
    // results
    output fpc_pkg::fpc_addr_t     addr_select,
    output fpc_pkg::fpc_req_t      action_req,
    output fpc_pkg::fpc_disp_t     display
);
    import fpc_pkg::*;

    // ************************************************************
    // pin synchronisers: three stages, change taken when 2 and 3 agree
    // ************************************************************
    localparam int unsigned PW = 13;
    logic [PW-1:0] pin_raw;
    logic [PW-1:0] s1_ff, s2_ff, s3_ff, clean_ff;
    logic [PW-1:0] nxt_s1, nxt_s2, nxt_s3, nxt_clean;

    assign pin_raw = {front_push_button, single_rotary_selector, units_rotary_selector, tens_rotary_selector};

    always_comb begin
        nxt_s1    = pin_raw;
        nxt_s2    = s1_ff;
        nxt_s3    = s2_ff;
        nxt_clean = clean_ff;
        for (int i = 0; i < PW; i++) begin
            if (s2_ff[i] == s3_ff[i]) begin
                nxt_clean[i] = s3_ff[i];
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s1_ff    <= '0;
            s2_ff    <= '0;
            s3_ff    <= '0;
            clean_ff <= '0;
        end else begin
            s1_ff    <= nxt_s1;
            s2_ff    <= nxt_s2;
            s3_ff    <= nxt_s3;
            clean_ff <= nxt_clean;
        end
    end

    logic [3:0] tens, units, single;
    logic       btn;
    assign tens   = clean_ff[3:0];
    assign units  = clean_ff[7:4];
    assign single = clean_ff[11:8];
    assign btn    = clean_ff[12];

    // ************************************************************
    // power-up address capture, once the synchronisers have settled
    // ************************************************************
    logic [2:0] settle_ff, nxt_settle;
    fpc_addr_t  addr_ff, nxt_addr;
    logic [7:0] two_digit;

    assign two_digit = 8'({4'h0, tens} * 8'h0A + {4'h0, units});

    always_comb begin
        nxt_settle = settle_ff;
        nxt_addr   = addr_ff;
        if (settle_ff != 3'h7) begin
            nxt_settle = 3'(settle_ff + 3'h1);
        end
        // selectors are read only at power-up; later turns are for actions
        if (settle_ff == 3'h6) begin
            nxt_addr.valid = 1'b1;
            if (single_selector_variant) begin
                if (single == 4'h0) begin
                    nxt_addr.mode       = ADDR_DHCP; // R8
                    nxt_addr.last_octet = 8'h00;
                end else if (single == SEL_SINGLE_SW) begin
                    nxt_addr.mode       = ADDR_STATIC_CFG; // R9
                    nxt_addr.last_octet = 8'h00;
                end else if (single >= SEL_SINGLE_MIN && single <= SEL_SINGLE_MAX) begin
                    nxt_addr.mode       = ADDR_STATIC_SEL; // R10
                    nxt_addr.last_octet = 8'(SINGLE_OCTET_BASE + {4'h0, single});
                end else begin
                    // out of range position leaves the selection invalid, mode DHCP
                    nxt_addr.mode       = ADDR_DHCP;
                    nxt_addr.last_octet = 8'h00;
                    nxt_addr.valid      = 1'b0;
                end
            end else if (tens == 4'h0 && units == 4'h0) begin
                nxt_addr.mode       = ADDR_DHCP; // R1
                nxt_addr.last_octet = 8'h00;
            end else begin
                nxt_addr.mode       = ADDR_STATIC_SEL; // R2
                nxt_addr.last_octet = two_digit;
                nxt_addr.valid      = (tens <= 4'h9) && (units <= 4'h9); // R2
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            settle_ff <= '0;
            addr_ff   <= '{mode: ADDR_DHCP, last_octet: 8'h00, valid: 1'b0};
        end else begin
            settle_ff <= nxt_settle;
            addr_ff   <= nxt_addr;
        end
    end
    assign addr_select = addr_ff;

    // ************************************************************
    // button hold timer and action dispatch
    // ************************************************************
    logic [CNT_W-1:0] hold_ff, nxt_hold;
    logic             fired_ff, nxt_fired;
    logic             btn_d_ff, nxt_btn_d;
    fpc_req_t         req_ff, nxt_req;
    logic             short_ff, nxt_short;
    logic             sel_toggle, sel_load, sel_save, sel_stop, sel_restart;
    logic             drive_idle;

    assign drive_idle  = power_present && !drive_enabled;
    assign sel_toggle  = fieldbus_variant && tens == SEL_TOGGLE_TENS && units == SEL_TOGGLE_UNITS;
    assign sel_load    = io_expansion_option && tens == SEL_SD_TENS && units == SEL_LOAD_UNITS;
    assign sel_save    = io_expansion_option && tens == SEL_SD_TENS && units == SEL_SAVE_UNITS;
    assign sel_stop    = programmable_variant && tens == SEL_SD_TENS && units == SEL_STOP_UNITS;
    assign sel_restart = programmable_variant && tens == SEL_SD_TENS && units == SEL_RESTART_UNITS;

    always_comb begin
        nxt_hold  = '0; // R16
        nxt_fired = 1'b0;
        nxt_btn_d = btn;
        nxt_req   = '0;
        nxt_short = 1'b0;
        if (btn) begin
            nxt_fired = fired_ff;
            nxt_hold  = (hold_ff == CNT_W'(ACTION_CYC)) ? hold_ff : CNT_W'(hold_ff + 1'b1); // R16
            if (!fired_ff && !single_selector_variant) begin
                if (hold_ff == CNT_W'(TOGGLE_CYC - 1) && sel_toggle && drive_idle) begin
                    nxt_req.fieldbus_toggle = 1'b1; // R3
                    nxt_fired               = 1'b1; // R16
                end
                if (hold_ff == CNT_W'(ACTION_CYC - 1)) begin
                    // refused requests still count as the press's one action
                    nxt_fired            = 1'b1; // R16
                    nxt_req.sd_load      = sel_load && drive_idle && !program_running; // R4 R15
                    nxt_req.sd_save      = sel_save && drive_idle && !program_running; // R5 R15
                    nxt_req.prog_stop    = sel_stop && power_present; // R6
                    nxt_req.prog_restart = sel_restart && power_present; // R7
                end
            end
        end else if (btn_d_ff && hold_ff < CNT_W'(TOGGLE_CYC - 1)) begin
            nxt_short = 1'b1; // R17
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            hold_ff  <= '0;
            fired_ff <= 1'b0;
            btn_d_ff <= 1'b0;
            req_ff   <= '0;
            short_ff <= 1'b0;
        end else begin
            hold_ff  <= nxt_hold;
            fired_ff <= nxt_fired;
            btn_d_ff <= nxt_btn_d;
            req_ff   <= nxt_req;
            short_ff <= nxt_short;
        end
    end
    assign action_req = req_ff;

    // ************************************************************
    // display: address sequence, status code, decimal point
    // ************************************************************
    typedef enum logic [1:0] {IPS_IDLE, IPS_TAG, IPS_HIGH, IPS_LOW} fpc_ip_state_t;
    fpc_ip_state_t    ip_st_ff, nxt_ip_st;
    logic [CNT_W-1:0] ip_cnt_ff, nxt_ip_cnt;
    logic [CNT_W-1:0] blink_ff, nxt_blink;
    logic             blink_on_ff, nxt_blink_on;
    fpc_disp_t        disp_ff, nxt_disp;
    logic [7:0]       oct_hi, oct_lo;

    // digits of the octet: hundreds and tens shown first, then units beside a blank
    assign oct_hi = CH_DIGIT0 + 8'(current_octet / 8'd100);
    assign oct_lo = CH_DIGIT0 + 8'(current_octet % 8'd10);

    always_comb begin
        nxt_ip_st    = ip_st_ff;
        nxt_ip_cnt   = ip_cnt_ff;
        nxt_blink    = CNT_W'(blink_ff + 1'b1);
        nxt_blink_on = blink_on_ff;
        if (blink_ff >= CNT_W'(BLINK_CYC - 1)) begin
            nxt_blink    = '0;
            nxt_blink_on = !blink_on_ff;
        end
        case (ip_st_ff)
            IPS_IDLE: begin
                nxt_ip_cnt = '0;
                if (short_ff) begin
                    nxt_ip_st = IPS_TAG; // R11
                end
            end
            IPS_TAG, IPS_HIGH, IPS_LOW: begin
                nxt_ip_cnt = CNT_W'(ip_cnt_ff + 1'b1);
                if (ip_cnt_ff >= CNT_W'(IPSHOW_CYC - 1)) begin
                    nxt_ip_cnt = '0;
                    case (ip_st_ff)
                        IPS_TAG:  nxt_ip_st = IPS_HIGH;
                        IPS_HIGH: nxt_ip_st = IPS_LOW;
                        default:  nxt_ip_st = IPS_IDLE;
                    endcase
                end
            end
            default: begin
                nxt_ip_st = IPS_IDLE;
            end
        endcase

        nxt_disp.dp = 1'b0;
        if (drive_activity_state == ACTIVE_DYN_BRAKE) begin
            nxt_disp.dp = blink_on_ff; // R13
        end else if (drive_enabled) begin
            nxt_disp.dp = 1'b1; // R13
        end
        if (!logic_image_ready) begin
            nxt_disp.left  = CH_LOADING; // R14
            nxt_disp.right = CH_LOADING;
            nxt_disp.dp    = 1'b0;
        end else if (download_active) begin
            nxt_disp.left  = CH_DNLD; // R12
            nxt_disp.right = CH_DIGIT0 + {4'h0, download_step};
        end else if (ip_st_ff == IPS_TAG) begin
            nxt_disp.left  = CH_IP_I; // R11
            nxt_disp.right = CH_IP_P;
        end else if (ip_st_ff == IPS_HIGH) begin
            nxt_disp.left  = oct_hi; // R11
            nxt_disp.right = CH_DIGIT0 + 8'((current_octet / 8'd10) % 8'd10);
        end else if (ip_st_ff == IPS_LOW) begin
            nxt_disp.left  = CH_BLANK;
            nxt_disp.right = oct_lo;
        end else if (fault_active) begin
            nxt_disp.left  = CH_FAULT; // R12
            nxt_disp.right = CH_DIGIT0 + {4'h0, fault_code};
        end else if (warning_active) begin
            nxt_disp.left  = CH_WARN; // R12
            nxt_disp.right = CH_DIGIT0 + {4'h0, warning_code};
        end else begin
            nxt_disp.left  = CH_OPER; // R12
            nxt_disp.right = CH_DIGIT0 + {6'h00, operating_mode};
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ip_st_ff    <= IPS_IDLE;
            ip_cnt_ff   <= '0;
            blink_ff    <= '0;
            blink_on_ff <= 1'b0;
            disp_ff     <= '{left: CH_LOADING, right: CH_LOADING, dp: 1'b0};
        end else begin
            ip_st_ff    <= nxt_ip_st;
            ip_cnt_ff   <= nxt_ip_cnt;
            blink_ff    <= nxt_blink;
            blink_on_ff <= nxt_blink_on;
            disp_ff     <= nxt_disp;
        end
    end
    assign display = disp_ff;

endmodule

/* bench/fpc_properties.sv */
/* fpc_properties: port assertions for fpc_front_panel, bound at the foot.
   assumes straps and drive state stay steady while the button is held. */
`timescale 1ns/1ps
module fpc_properties #(
    parameter longint unsigned BLINK_CYC = 4
) (
    // clock and reset
    input logic               clk,
    input logic               rst_n,
    // straps, pins and drive state
    input logic               single_selector_variant,
    input logic               fieldbus_variant,
    input logic               io_expansion_option,
    input logic               programmable_variant,
    input logic               front_push_button,
    input logic               logic_image_ready,
    input logic               power_present,
    input logic               drive_enabled,
    input logic               program_running,
    input logic [1:0]         drive_activity_state,
    // results
    input fpc_pkg::fpc_addr_t addr_select,
    input fpc_pkg::fpc_req_t  action_req,
    input fpc_pkg::fpc_disp_t display
);
    import fpc_pkg::*;
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);

    // ****
    // helper counters
    // ****
    // pulses counted per press at the pin; sync lag may land one after release
    logic [7:0] run_ff, nxt_run;
    logic [1:0] cnt_ff, nxt_cnt;
    logic       dp_ff, nxt_dp;
    always_comb begin
        nxt_run = 8'h00;
        nxt_dp = display.dp;
        if (logic_image_ready && drive_activity_state == ACTIVE_DYN_BRAKE && display.dp == dp_ff) begin
            nxt_run = (run_ff == 8'hFF) ? run_ff : run_ff + 8'h01;
        end
        nxt_cnt = front_push_button ? cnt_ff : 2'h0;
        if (action_req != '0 && nxt_cnt != 2'h3) begin
            nxt_cnt = nxt_cnt + 2'h1;
        end
    end
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            run_ff <= 8'h00;
            cnt_ff <= 2'h0;
            dp_ff <= 1'b0;
        end else begin
            run_ff <= nxt_run;
            cnt_ff <= nxt_cnt;
            dp_ff <= nxt_dp;
        end
    end

    // ****
    // properties
    // ****
    sequence dp_steady_s;
        (logic_image_ready && drive_activity_state != ACTIVE_DYN_BRAKE && $stable(drive_enabled)) [*3];
    endsequence
    sequence loading_s;
        (!logic_image_ready) [*2];
    endsequence

    req_pulse_a: assert property (action_req != '0 |=> action_req == '0)
        else $error("request wider than one cycle");
    press_once_a: assert property (cnt_ff <= 2'h1)
        else $error("second action in one press");
    req_held_a: assert property (action_req != '0 |-> $past(front_push_button, 8) && $past(front_push_button, 30))
        else $error("action without a held button");
    sd_gate_a: assert property ((action_req.sd_load || action_req.sd_save) |->
        $past(io_expansion_option && power_present && !drive_enabled && !program_running))
        else $error("card transfer not allowed");
    toggle_gate_a: assert property (action_req.fieldbus_toggle |->
        $past(fieldbus_variant && power_present && !drive_enabled))
        else $error("toggle not allowed");
    prog_gate_a: assert property ((action_req.prog_stop || action_req.prog_restart) |->
        $past(programmable_variant && power_present))
        else $error("program action not allowed");
    single_idle_a: assert property (single_selector_variant |-> action_req == '0)
        else $error("action on single selector unit");
    addr_hold_a: assert property (addr_select.valid |=> $stable(addr_select))
        else $error("address selection changed");
    dp_steady_a: assert property (dp_steady_s |-> display.dp == drive_enabled)
        else $error("point does not follow enable");
    dp_flash_a: assert property (run_ff < BLINK_CYC + 3)
        else $error("point not flashing");
    loading_code_a: assert property (loading_s |-> display.left == CH_LOADING)
        else $error("loading code missing");
endmodule

bind fpc_front_panel fpc_properties #(.BLINK_CYC(BLINK_CYC)) fpc_properties_i (
    .clk, .rst_n, .single_selector_variant, .fieldbus_variant, .io_expansion_option, .programmable_variant,
    .front_push_button, .logic_image_ready, .power_present, .drive_enabled, .program_running,
    .drive_activity_state, .addr_select, .action_req, .display);

/* bench/fpc_operator.sv */
/* fpc_operator: the person at the panel; turns selectors, holds the button.
   assumes it is told what to do 1 ns after a rising edge of clk. */
`timescale 1ns/1ps
module fpc_operator (
    // clock
    input  logic       clk,
    // panel pins
    output logic [3:0] tens_rotary_selector,
    output logic [3:0] units_rotary_selector,
    output logic [3:0] single_rotary_selector,
    output logic       front_push_button
);
    initial begin
        set_sel(4'h0, 4'h0, 4'h0);
        front_push_button = 1'b0;
    end
    // selectors only move while the logic supply is off
    task automatic set_sel(input logic [3:0] t, u, s);
        tens_rotary_selector = t;
        units_rotary_selector = u;
        single_rotary_selector = s;
    endtask
    task automatic press(input int cycles);
        @(posedge clk);
        #1;
        front_push_button = 1'b1;
        repeat (cycles) @(posedge clk);
        #1;
        front_push_button = 1'b0;
    endtask
endmodule

/* bench/front_panel_controller_bench.sv */
/* front_panel_controller_bench: address, action and display tests.
   assumes hold and display times shortened through parameters. */
`timescale 1ns/1ps
module front_panel_controller_bench;
    import fpc_pkg::*;
    logic clk, rst_n, single_selector_variant, fieldbus_variant, io_expansion_option, programmable_variant;
    logic logic_image_ready, power_present, drive_enabled, program_running;
    logic fault_active, warning_active, download_active, front_push_button;
    logic [1:0] drive_activity_state, operating_mode;
    logic [3:0] fault_code, warning_code, download_step;
    logic [3:0] tens_rotary_selector, units_rotary_selector, single_rotary_selector;
    logic [7:0] current_octet;
    logic [4:0] got;
    fpc_addr_t addr_select;
    fpc_req_t  action_req;
    fpc_disp_t display;
    int num_errors = 0;
    int total_checks = 0;
    int npulse;

    fpc_front_panel #(.TOGGLE_CYC(40), .ACTION_CYC(60), .BLINK_CYC(4), .IPSHOW_CYC(10)) fpc_front_panel_i (
        .clk, .rst_n, .single_selector_variant, .fieldbus_variant, .io_expansion_option, .programmable_variant,
        .tens_rotary_selector, .units_rotary_selector, .single_rotary_selector, .front_push_button,
        .logic_image_ready, .power_present, .drive_enabled, .program_running, .drive_activity_state,
        .operating_mode, .fault_active, .fault_code, .warning_active, .warning_code, .download_active,
        .download_step, .current_octet, .addr_select, .action_req, .display);
    fpc_operator fpc_operator_i (.clk, .tens_rotary_selector, .units_rotary_selector, .single_rotary_selector,
        .front_push_button);

    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    always @(posedge clk) begin
        if (action_req != '0) begin
            got = got | action_req;
            npulse++;
        end
    end

    // ****
    // tasks
    // ****
    task automatic check(input string what, input logic [15:0] exp, input logic [15:0] seen);
        total_checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic power_up(input logic sv, input logic [3:0] t, u, s);
        rst_n = 1'b0;
        single_selector_variant = sv;
        fpc_operator_i.set_sel(t, u, s);
        repeat (12) @(posedge clk);
        #1 rst_n = 1'b1;
        repeat (12) @(posedge clk);
        #1;
    endtask
    task automatic addr_case(input logic sv, input logic [3:0] t, u, s, input fpc_addr_mode_t m, input logic v);
        logic [7:0] oct;
        oct = sv ? SINGLE_OCTET_BASE + 8'(s) : 8'(t) * 8'h0A + 8'(u);
        power_up(sv, t, u, s);
        check("addr_valid", 16'(v), 16'(addr_select.valid));
        if (v) check("addr_mode", 16'(m), 16'(addr_select.mode));
        if (v && m == ADDR_STATIC_SEL) check("addr_octet", 16'(oct), 16'(addr_select.last_octet));
    endtask
    task automatic act_case(input logic [3:0] t, u, input logic [2:0] vars, cond, input int hold, input logic [4:0] exp);
        {fieldbus_variant, io_expansion_option, programmable_variant} = vars;
        power_up(1'b0, t, u, 4'h0);
        {power_present, drive_enabled, program_running} = cond;
        got = '0;
        npulse = 0;
        fpc_operator_i.press(hold);
        repeat (20) @(posedge clk);
        #1;
        check("action_req", 16'(exp), 16'(got));
        check("pulse_count", 16'(exp != '0), 16'(npulse));
    endtask
    task automatic wait_disp(input logic [7:0] l, r, input int lim);
        for (int n = 0; {display.left, display.right} !== {l, r} && n < lim; n++) begin
            @(posedge clk);
            #1;
        end
        check("display", {l, r}, {display.left, display.right});
    endtask
    task automatic wait_dp(input logic v);
        for (int n = 0; display.dp !== v && n < 16; n++) begin
            @(posedge clk);
            #1;
        end
        check("display_dp", 16'(v), 16'(display.dp));
    endtask
    task automatic test_done;
        if (num_errors == 0 && total_checks > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask

    // ****
    // tests
    // ****
    initial begin
        rst_n = 1'b0;
        {single_selector_variant, fieldbus_variant, io_expansion_option, programmable_variant} = 4'h0;
        {logic_image_ready, power_present, drive_enabled, program_running} = 4'h0;
        {fault_active, warning_active, download_active, drive_activity_state, operating_mode} = 7'h00;
        {fault_code, warning_code, download_step} = 12'h000;
        current_octet = 8'h8E;
        #1;
        addr_case(1'b0, 4'h0, 4'h0, 4'h0, ADDR_DHCP, 1'b1);
        addr_case(1'b0, 4'h0, 4'h1, 4'h0, ADDR_STATIC_SEL, 1'b1);
        addr_case(1'b0, 4'h9, 4'h9, 4'h0, ADDR_STATIC_SEL, 1'b1);
        addr_case(1'b0, 4'hA, 4'h3, 4'h0, ADDR_STATIC_SEL, 1'b0);
        addr_case(1'b1, 4'h5, 4'h5, 4'h0, ADDR_DHCP, 1'b1);
        addr_case(1'b1, 4'h5, 4'h5, 4'h1, ADDR_STATIC_CFG, 1'b1);
        addr_case(1'b1, 4'h0, 4'h0, 4'h2, ADDR_STATIC_SEL, 1'b1);
        addr_case(1'b1, 4'h0, 4'h0, 4'h9, ADDR_STATIC_SEL, 1'b1);
        act_case(4'h8, 4'h9, 3'h7, 3'h4, 70, 5'h10);
        act_case(4'h8, 4'h9, 3'h7, 3'h6, 70, 5'h00);
        act_case(4'h1, 4'h0, 3'h7, 3'h4, 70, 5'h08);
        act_case(4'h1, 4'h0, 3'h5, 3'h4, 70, 5'h00);
        act_case(4'h1, 4'h0, 3'h7, 3'h4, 50, 5'h00);
        act_case(4'h1, 4'h1, 3'h7, 3'h4, 70, 5'h04);
        act_case(4'h1, 4'h1, 3'h7, 3'h5, 70, 5'h00);
        act_case(4'h1, 4'h2, 3'h7, 3'h6, 70, 5'h02);
        act_case(4'h1, 4'h3, 3'h7, 3'h4, 70, 5'h01);
        act_case(4'h1, 4'h3, 3'h7, 3'h0, 70, 5'h00);
        act_case(4'h5, 4'h5, 3'h7, 3'h4, 70, 5'h00);
        power_up(1'b0, 4'h0, 4'h0, 4'h0);
        wait_disp(CH_LOADING, CH_LOADING, 20);
        logic_image_ready = 1'b1;
        operating_mode = 2'h2;
        wait_disp(CH_OPER, CH_DIGIT0 + 8'h02, 20);
        {warning_active, warning_code} = 5'h17;
        wait_disp(CH_WARN, CH_DIGIT0 + 8'h07, 20);
        {fault_active, fault_code} = 5'h15;
        wait_disp(CH_FAULT, CH_DIGIT0 + 8'h05, 20);
        {download_active, download_step} = 5'h13;
        wait_disp(CH_DNLD, CH_DIGIT0 + 8'h03, 20);
        {fault_active, warning_active, download_active} = 3'h0;
        fpc_operator_i.press(8);
        wait_disp(CH_IP_I, CH_IP_P, 30);
        wait_disp(CH_DIGIT0 + current_octet / 100, CH_DIGIT0 + current_octet / 10 % 10, 15);
        wait_disp(CH_BLANK, CH_DIGIT0 + current_octet % 10, 15);
        wait_disp(CH_OPER, CH_DIGIT0 + 8'h02, 20);
        drive_enabled = 1'b1;
        wait_dp(1'b1);
        drive_activity_state = 2'h3;
        wait_dp(1'b0);
        wait_dp(1'b1);
        {drive_activity_state, drive_enabled} = 3'h0;
        wait_dp(1'b0);
        test_done;
    end
    initial begin
        repeat (20000) @(posedge clk);
        num_errors++;
        test_done;
    end
endmodule
